// ---- logic/vts_top.sv ----
// vector table select, flag/enable/priority registers, apb slave
// assumes apb master in pclk domain and single-cycle source event pulses
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module vts_top #(
  parameter int TBL_ENTRIES = vts_pkg::VTS_TBL_ENTRIES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [vts_pkg::VTS_NSRC-1:0] src_evt,
  output logic irq,
  output logic alt_table_select,
  output logic vec_vld,
  output logic [2:0] vec_pri,
  output logic [23:0] vec_addr
);

  localparam logic [23:0] ALT_BASE = vts_pkg::VTS_DEF_BASE +
    24'(TBL_ENTRIES * 2);

  vts_pkg::vts_state_t st_ff;
  vts_pkg::vts_state_t nxt_st;
  logic setup;
  logic acc;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [23:0] slot_off;

  vts_arb_if ab ();

  vts_arb u_arb (
    .a(ab)
  );

  assign ab.pend = st_ff.flg & st_ff.en;
  assign ab.pri = st_ff.pri;
  assign setup = psel && !penable;
  assign acc = psel && penable && st_ff.rdy;
  assign slot_off = 24'(vts_pkg::VTS_SRC_SLOT[ab.win_idx]) *
    vts_pkg::VTS_VEC_STEP;

  // read mux; bits not listed stay zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      vts_pkg::VTS_OFF_ICTL2: begin
        rd_val[vts_pkg::VTS_ALT_BIT] = st_ff.alt;
      end
      vts_pkg::VTS_OFF_FS3: begin
        rd_val[vts_pkg::VTS_PWM_FLAG_BIT] =
          st_ff.flg[vts_pkg::VTS_SRC_PWM];
      end
      vts_pkg::VTS_OFF_FS4: begin
        rd_val[vts_pkg::VTS_SER_FLAG_BIT] =
          st_ff.flg[vts_pkg::VTS_SRC_SER];
      end
      vts_pkg::VTS_OFF_EC7: begin
        rd_val[vts_pkg::VTS_ADC6_BIT] = st_ff.en[vts_pkg::VTS_SRC_ADC6];
        rd_val[vts_pkg::VTS_ADC3_BIT] = st_ff.en[vts_pkg::VTS_SRC_ADC3];
        rd_val[vts_pkg::VTS_ADC2_BIT] = st_ff.en[vts_pkg::VTS_SRC_ADC2];
      end
      vts_pkg::VTS_OFF_PC29: begin
        rd_val[vts_pkg::VTS_PRI6_LSB +: 3] =
          st_ff.pri[vts_pkg::VTS_SRC_ADC6];
      end
      vts_pkg::VTS_OFF_ADCF: begin
        rd_val[vts_pkg::VTS_ADC6_BIT] = st_ff.flg[vts_pkg::VTS_SRC_ADC6];
        rd_val[vts_pkg::VTS_ADC3_BIT] = st_ff.flg[vts_pkg::VTS_SRC_ADC3];
        rd_val[vts_pkg::VTS_ADC2_BIT] = st_ff.flg[vts_pkg::VTS_SRC_ADC2];
      end
      vts_pkg::VTS_OFF_SEN: begin
        rd_val[vts_pkg::VTS_SEN_PWM_BIT] = st_ff.en[vts_pkg::VTS_SRC_PWM];
        rd_val[vts_pkg::VTS_SEN_SER_BIT] = st_ff.en[vts_pkg::VTS_SRC_SER];
      end
      vts_pkg::VTS_OFF_SPRI: begin
        rd_val[vts_pkg::VTS_SPRI_PWM_LSB +: 3] =
          st_ff.pri[vts_pkg::VTS_SRC_PWM];
        rd_val[vts_pkg::VTS_SPRI_SER_LSB +: 3] =
          st_ff.pri[vts_pkg::VTS_SRC_SER];
        rd_val[vts_pkg::VTS_SPRI_ADC3_LSB +: 3] =
          st_ff.pri[vts_pkg::VTS_SRC_ADC3];
        rd_val[vts_pkg::VTS_SPRI_ADC2_LSB +: 3] =
          st_ff.pri[vts_pkg::VTS_SRC_ADC2];
      end
      vts_pkg::VTS_OFF_ISTS: begin
        rd_val[vts_pkg::VTS_NSRC-1:0] = st_ff.sts;
      end
      vts_pkg::VTS_OFF_IMSK: begin
        rd_val[vts_pkg::VTS_NSRC-1:0] = st_ff.msk;
      end
      vts_pkg::VTS_OFF_VSTS: begin
        rd_val[23:0] = st_ff.vaddr;
        rd_val[vts_pkg::VTS_VSTS_PRI_LSB +: 3] = st_ff.vpri;
        rd_val[vts_pkg::VTS_VSTS_ALT_BIT] = st_ff.valt;
        rd_val[vts_pkg::VTS_VSTS_VLD_BIT] = st_ff.vld;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      // read data is latched in setup so pready and prdata leave flops
      nxt_st.rdy = setup;
      nxt_st.err = setup && !rd_hit;
      nxt_st.rdata = (setup && !pwrite) ? rd_val : 32'h0000_0000;
      if (acc && pwrite) begin
        case (paddr)
          vts_pkg::VTS_OFF_ICTL2: begin
            nxt_st.alt = pwdata[vts_pkg::VTS_ALT_BIT];
          end
          vts_pkg::VTS_OFF_FS3: begin
            nxt_st.flg[vts_pkg::VTS_SRC_PWM] =
              pwdata[vts_pkg::VTS_PWM_FLAG_BIT];
          end
          vts_pkg::VTS_OFF_FS4: begin
            nxt_st.flg[vts_pkg::VTS_SRC_SER] =
              pwdata[vts_pkg::VTS_SER_FLAG_BIT];
          end
          vts_pkg::VTS_OFF_EC7: begin
            nxt_st.en[vts_pkg::VTS_SRC_ADC6] =
              pwdata[vts_pkg::VTS_ADC6_BIT];
            nxt_st.en[vts_pkg::VTS_SRC_ADC3] =
              pwdata[vts_pkg::VTS_ADC3_BIT];
            nxt_st.en[vts_pkg::VTS_SRC_ADC2] =
              pwdata[vts_pkg::VTS_ADC2_BIT];
          end
          vts_pkg::VTS_OFF_PC29: begin
            nxt_st.pri[vts_pkg::VTS_SRC_ADC6] =
              pwdata[vts_pkg::VTS_PRI6_LSB +: 3];
          end
          vts_pkg::VTS_OFF_ADCF: begin
            nxt_st.flg[vts_pkg::VTS_SRC_ADC6] = pwdata[vts_pkg::VTS_ADC6_BIT];
            nxt_st.flg[vts_pkg::VTS_SRC_ADC3] = pwdata[vts_pkg::VTS_ADC3_BIT];
            nxt_st.flg[vts_pkg::VTS_SRC_ADC2] = pwdata[vts_pkg::VTS_ADC2_BIT];
          end
          vts_pkg::VTS_OFF_SEN: begin
            nxt_st.en[vts_pkg::VTS_SRC_PWM] = pwdata[vts_pkg::VTS_SEN_PWM_BIT];
            nxt_st.en[vts_pkg::VTS_SRC_SER] = pwdata[vts_pkg::VTS_SEN_SER_BIT];
          end
          vts_pkg::VTS_OFF_SPRI: begin
            nxt_st.pri[vts_pkg::VTS_SRC_PWM] =
              pwdata[vts_pkg::VTS_SPRI_PWM_LSB +: 3];
            nxt_st.pri[vts_pkg::VTS_SRC_SER] =
              pwdata[vts_pkg::VTS_SPRI_SER_LSB +: 3];
            nxt_st.pri[vts_pkg::VTS_SRC_ADC3] =
              pwdata[vts_pkg::VTS_SPRI_ADC3_LSB +: 3];
            nxt_st.pri[vts_pkg::VTS_SRC_ADC2] =
              pwdata[vts_pkg::VTS_SPRI_ADC2_LSB +: 3];
          end
          vts_pkg::VTS_OFF_IMSK: begin
            nxt_st.msk = pwdata[vts_pkg::VTS_NSRC-1:0];
          end
          default: begin
            nxt_st.msk = st_ff.msk;
          end
        endcase
      end
      // clear only what the read returned, so a late event survives
      if (acc && !pwrite && paddr == vts_pkg::VTS_OFF_ISTS) begin
        nxt_st.sts = st_ff.sts & ~st_ff.rdata[vts_pkg::VTS_NSRC-1:0];
      end
      // hardware set wins over a software clear in the same cycle
      nxt_st.flg = nxt_st.flg | src_evt;
      nxt_st.sts = nxt_st.sts | src_evt;
      nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
      nxt_st.vld = ab.win_vld;
      nxt_st.vsrc = ab.win_idx;
      nxt_st.vpri = ab.win_pri;
      nxt_st.valt = st_ff.alt;
      // with nothing pending the address rests at the reset fetch point
      nxt_st.vaddr = ab.win_vld ?
        ((st_ff.alt ? ALT_BASE : vts_pkg::VTS_DEF_BASE) + slot_off) :
        vts_pkg::VTS_RESET_PC;
    end
  end

  // reset forces fetch address to zero and raises no vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= vts_pkg::VTS_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.err;
  assign irq = st_ff.irq;
  assign alt_table_select = st_ff.alt;
  assign vec_vld = st_ff.vld;
  assign vec_pri = st_ff.vpri;
  assign vec_addr = st_ff.vaddr;

  logic [23:0] exp_addr;
  assign exp_addr = (st_ff.valt ? ALT_BASE : vts_pkg::VTS_DEF_BASE) +
    24'(vts_pkg::VTS_SRC_SLOT[st_ff.vsrc]) * vts_pkg::VTS_VEC_STEP;

  a_alt_table_follow: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) && vec_vld |-> st_ff.valt == $past(st_ff.alt))
    else $error("vector table select not followed");
  a_slot_layout_same: assert property (@(posedge pclk) disable iff (!presetn)
    vec_vld |-> vec_addr == exp_addr)
    else $error("vector address off the slot layout");
  a_reset_pc_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> vec_addr == vts_pkg::VTS_RESET_PC
      && st_ff.flg == '0 && st_ff.en == '0)
    else $error("registers not cleared by reset");
  a_reset_no_vector: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> !vec_vld && !irq)
    else $error("vector presented for reset");
  a_pwm_flag_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && acc && pwrite && paddr == vts_pkg::VTS_OFF_FS3 |=>
      st_ff.flg[0] == ($past(pwdata[9]) | $past(src_evt[0])))
    else $error("pwm match flag write lost");
  a_serial_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && src_evt[1] |=> st_ff.flg[1])
    else $error("serial error flag not set");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && (paddr == vts_pkg::VTS_OFF_EC7) |->
      (prdata & 32'hFFFF_FFEC) == 32'h0000_0000)
    else $error("unimplemented bits read nonzero");
  a_pri6_disable: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) && $past(st_ff.pri[2]) == 3'h0 |-> !(vec_vld
      && st_ff.vsrc == 3'h2))
    else $error("priority zero source won");
  a_request_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) && vec_vld |-> $past(|(st_ff.flg & st_ff.en)) &&
      vec_pri != 3'h0)
    else $error("vector without pending enabled source");
  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && acc && pwrite && paddr == vts_pkg::VTS_OFF_EC7 |=>
      st_ff.en[4:2] == {$past(pwdata[0]), $past(pwdata[1]),
        $past(pwdata[4])})
    else $error("enable seven write misplaced");

  c_alt_vector: cover property (@(posedge pclk) vec_vld && st_ff.valt);
  c_irq_raised: cover property (@(posedge pclk) $rose(irq));
  c_set_and_clear: cover property (@(posedge pclk)
    acc && !pwrite && paddr == vts_pkg::VTS_OFF_ISTS && |src_evt);

endmodule : vts_top

// ---- logic/vts_pkg.sv ----
// vector table select and interrupt register fragment: shared constants
// assumes a 32-bit apb slave with byte addresses on 8 address bits
package vts_pkg;

  localparam int VTS_NSRC = 5;
  localparam int VTS_SRC_PWM = 0;
  localparam int VTS_SRC_SER = 1;
  localparam int VTS_SRC_ADC6 = 2;
  localparam int VTS_SRC_ADC3 = 3;
  localparam int VTS_SRC_ADC2 = 4;

  // register byte offsets
  localparam logic [7:0] VTS_OFF_ICTL2 = 8'h00;
  localparam logic [7:0] VTS_OFF_FS3 = 8'h04;
  localparam logic [7:0] VTS_OFF_FS4 = 8'h08;
  localparam logic [7:0] VTS_OFF_EC7 = 8'h0C;
  localparam logic [7:0] VTS_OFF_PC29 = 8'h10;
  localparam logic [7:0] VTS_OFF_ADCF = 8'h14;
  localparam logic [7:0] VTS_OFF_SEN = 8'h18;
  localparam logic [7:0] VTS_OFF_SPRI = 8'h1C;
  localparam logic [7:0] VTS_OFF_ISTS = 8'h20;
  localparam logic [7:0] VTS_OFF_IMSK = 8'h24;
  localparam logic [7:0] VTS_OFF_VSTS = 8'h28;

  // field positions
  localparam int VTS_ALT_BIT = 15;
  localparam int VTS_PWM_FLAG_BIT = 9;
  localparam int VTS_SER_FLAG_BIT = 1;
  localparam int VTS_ADC6_BIT = 4;
  localparam int VTS_ADC3_BIT = 1;
  localparam int VTS_ADC2_BIT = 0;
  localparam int VTS_PRI6_LSB = 0;
  localparam int VTS_SEN_PWM_BIT = 0;
  localparam int VTS_SEN_SER_BIT = 1;
  localparam int VTS_SPRI_PWM_LSB = 0;
  localparam int VTS_SPRI_SER_LSB = 4;
  localparam int VTS_SPRI_ADC3_LSB = 8;
  localparam int VTS_SPRI_ADC2_LSB = 12;
  localparam int VTS_VSTS_PRI_LSB = 24;
  localparam int VTS_VSTS_ALT_BIT = 30;
  localparam int VTS_VSTS_VLD_BIT = 31;

  // reset values and vector geometry
  localparam logic [2:0] VTS_PRI_RST = 3'h4;
  localparam logic [2:0] VTS_PRI_OFF = 3'h0;
  localparam logic [23:0] VTS_RESET_PC = 24'h00_0000;
  localparam logic [23:0] VTS_DEF_BASE = 24'h00_0004;
  localparam logic [23:0] VTS_VEC_STEP = 24'h00_0002;
  localparam int VTS_TBL_ENTRIES = 126;
  // slot of each source inside a table, same in both tables
  localparam logic [VTS_NSRC-1:0][6:0] VTS_SRC_SLOT =
    {7'h4C, 7'h4B, 7'h4A, 7'h49, 7'h48};

  typedef struct packed {
    logic alt;
    logic [VTS_NSRC-1:0] flg;
    logic [VTS_NSRC-1:0] en;
    logic [VTS_NSRC-1:0][2:0] pri;
    logic [VTS_NSRC-1:0] sts;
    logic [VTS_NSRC-1:0] msk;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic irq;
    logic vld;
    logic valt;
    logic [2:0] vsrc;
    logic [2:0] vpri;
    logic [23:0] vaddr;
  } vts_state_t;

  localparam vts_state_t VTS_ST_RST = '{
    alt: 1'b0, flg: '0, en: '0, pri: {VTS_NSRC{VTS_PRI_RST}},
    sts: '0, msk: '0, rdata: 32'h0000_0000, rdy: 1'b0, err: 1'b0,
    irq: 1'b0, vld: 1'b0, valt: 1'b0, vsrc: 3'h0, vpri: 3'h0,
    vaddr: VTS_RESET_PC};

endpackage : vts_pkg

// ---- logic/vts_arb_if.sv ----
// carrier between the register block and the priority picker
// assumes both ends sit in the same pclk domain
`timescale 1ns/1ps
interface vts_arb_if;
  logic [vts_pkg::VTS_NSRC-1:0] pend;
  logic [vts_pkg::VTS_NSRC-1:0][2:0] pri;
  logic win_vld;
  logic [2:0] win_idx;
  logic [2:0] win_pri;
  modport regs (output pend, output pri,
                input win_vld, input win_idx, input win_pri);
  modport arb (input pend, input pri,
               output win_vld, output win_idx, output win_pri);
endinterface : vts_arb_if

// ---- logic/vts_arb.sv ----
// combinational priority picker over the pending sources
// assumes pend already folds in flag and enable
`timescale 1ns/1ps
module vts_arb (
  vts_arb_if.arb a
);

  logic [2:0] best_pri;
  logic [2:0] best_idx;

  // strict compare: on equal priority the lower slot keeps the win
  always_comb begin
    best_pri = vts_pkg::VTS_PRI_OFF;
    best_idx = 3'h0;
    for (int i = 0; i < vts_pkg::VTS_NSRC; i++) begin
      if (a.pend[i] && a.pri[i] > best_pri) begin
        best_pri = a.pri[i];
        best_idx = 3'(i);
      end
    end
  end

  assign a.win_vld = best_pri != vts_pkg::VTS_PRI_OFF;
  assign a.win_idx = best_idx;
  assign a.win_pri = best_pri;

endmodule : vts_arb

// ---- sim/vts_src_model.sv ----
// partner model: event sources and the core's view of program memory
// assumes pulse() is called right after a rising pclk edge
`timescale 1ns/1ps
module vts_src_model #(
  parameter int TBL_ENTRIES = 126,
  parameter logic [23:0] HDL_DEF = 24'h00_0200,
  parameter logic [23:0] HDL_BASE = 24'h00_0400
) (
  input wire logic pclk,
  output logic [vts_pkg::VTS_NSRC-1:0] src_evt
);
  logic [23:0] pmem [0:255];
  int s;

  initial begin
    src_evt = '0;
    // unused slots of both tables point at the reset handler
    for (s = 0; s < 256; s++) pmem[s] = HDL_DEF;
    // alternate table is not needed, so it mirrors the default one
    for (s = 0; s < vts_pkg::VTS_NSRC; s++) begin
      pmem[2 + vts_pkg::VTS_SRC_SLOT[s]] = HDL_BASE + 24'(16 * s);
      pmem[2 + TBL_ENTRIES + vts_pkg::VTS_SRC_SLOT[s]] =
        HDL_BASE + 24'(16 * s);
    end
  end

  function automatic logic [23:0] fetch(input logic [23:0] a);
    return pmem[a[8:1]];
  endfunction : fetch

  // one-cycle event pulse, as a peripheral raises it
  task automatic pulse(input logic [vts_pkg::VTS_NSRC-1:0] m);
    src_evt <= m;
    @(posedge pclk);
    src_evt <= '0;
  endtask : pulse
endmodule : vts_src_model

// ---- sim/vts_top_test.sv ----
// self-checking bench for the vector select and interrupt registers
// assumes zero-wait apb answers and a single pclk domain
`timescale 1ns/1ps
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, (g), (x)); end end
module vts_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic alt_table_select;
  logic vec_vld;
  logic [2:0] vec_pri;
  logic [23:0] vec_addr;
  logic [4:0] src_evt;
  logic [31:0] q;
  logic e;
  int n_fail = 0;
  int checked = 0;

  always #2 pclk = ~pclk;

  vts_top #(.TBL_ENTRIES(126)) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_evt(src_evt), .irq(irq), .alt_table_select(alt_table_select),
    .vec_vld(vec_vld), .vec_pri(vec_pri), .vec_addr(vec_addr)
  );

  vts_src_model #(.TBL_ENTRIES(126)) src (
    .pclk(pclk), .src_evt(src_evt)
  );

  task automatic results();
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : wt

  // one apb transfer; result left in q and e
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t bus timeout", $time);
      results();
    end
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(q, x)
  endtask : rdchk

  // alternate base sits 126 two-byte entries (2 * 126 bytes) above the default base
  function automatic logic [23:0] va(input int s, input logic alt);
    return vts_pkg::VTS_DEF_BASE + (alt ? 24'h00_00FC : 24'h00_0000)
      + 24'(2 * vts_pkg::VTS_SRC_SLOT[s]);
  endfunction : va

  task automatic t_reset();
    `CHK(vec_addr, vts_pkg::VTS_RESET_PC)
    `CHK(vec_vld, 1'b0)
    `CHK(irq, 1'b0)
    rdchk(vts_pkg::VTS_OFF_ICTL2, 32'h0000_0000);
    rdchk(vts_pkg::VTS_OFF_FS3, 32'h0000_0000);
    rdchk(vts_pkg::VTS_OFF_FS4, 32'h0000_0000);
    rdchk(vts_pkg::VTS_OFF_EC7, 32'h0000_0000);
    rdchk(vts_pkg::VTS_OFF_PC29, 32'h0000_0004);
    rdchk(vts_pkg::VTS_OFF_SPRI, 32'h0000_4444);
  endtask : t_reset

  task automatic t_bits();
    apb(1'b1, vts_pkg::VTS_OFF_FS3, 32'hFFFF_FFFF);
    apb(1'b1, vts_pkg::VTS_OFF_FS4, 32'hFFFF_FFFF);
    apb(1'b1, vts_pkg::VTS_OFF_EC7, 32'hFFFF_FFFF);
    apb(1'b1, vts_pkg::VTS_OFF_PC29, 32'hFFFF_FFFF);
    rdchk(vts_pkg::VTS_OFF_FS3, 32'h0000_0200);
    rdchk(vts_pkg::VTS_OFF_FS4, 32'h0000_0002);
    rdchk(vts_pkg::VTS_OFF_EC7, 32'h0000_0013);
    rdchk(vts_pkg::VTS_OFF_PC29, 32'h0000_0007);
    // flags set but their sources stay disabled
    `CHK(vec_vld, 1'b0)
    apb(1'b0, 8'h2C, 32'h0000_0000);
    `CHK(e, 1'b1)
    `CHK(q, 32'h0000_0000)
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    wt(1);
    t_reset();
  endtask : t_bits

  task automatic t_event();
    apb(1'b1, vts_pkg::VTS_OFF_IMSK, 32'h0000_001F);
    apb(1'b1, vts_pkg::VTS_OFF_SEN, 32'h0000_0001);
    src.pulse(5'h01);
    #1;
    `CHK(irq, 1'b1)
    wt(1);
    `CHK(vec_vld, 1'b1)
    `CHK(vec_pri, 3'h4)
    `CHK(vec_addr, va(0, 1'b0))
    `CHK(src.fetch(vec_addr), 24'h00_0400)
    rdchk(vts_pkg::VTS_OFF_FS3, 32'h0000_0200);
    rdchk(vts_pkg::VTS_OFF_ISTS, 32'h0000_0001);
    wt(1);
    `CHK(irq, 1'b0)
    apb(1'b1, vts_pkg::VTS_OFF_ICTL2, 32'h0000_8000);
    wt(2);
    `CHK(alt_table_select, 1'b1)
    `CHK(vec_addr, va(0, 1'b1))
    `CHK(src.fetch(vec_addr), 24'h00_0400)
    rdchk(vts_pkg::VTS_OFF_VSTS, {8'hC4, va(0, 1'b1)});
    apb(1'b1, vts_pkg::VTS_OFF_SPRI, 32'h0000_4440);
    wt(2);
    `CHK(vec_vld, 1'b0)
    apb(1'b1, vts_pkg::VTS_OFF_ICTL2, 32'h0000_0000);
    apb(1'b1, vts_pkg::VTS_OFF_FS3, 32'h0000_0000);
  endtask : t_event

  task automatic t_arb();
    apb(1'b1, vts_pkg::VTS_OFF_EC7, 32'h0000_0011);
    apb(1'b1, vts_pkg::VTS_OFF_PC29, 32'h0000_0007);
    src.pulse(5'h14);
    wt(1);
    `CHK(vec_pri, 3'h7)
    `CHK(vec_addr, va(2, 1'b0))
    rdchk(vts_pkg::VTS_OFF_ADCF, 32'h0000_0011);
    apb(1'b1, vts_pkg::VTS_OFF_PC29, 32'h0000_0001);
    wt(2);
    `CHK(vec_pri, 3'h4)
    `CHK(vec_addr, va(4, 1'b0))
    src.pulse(5'h02);
    wt(1);
    rdchk(vts_pkg::VTS_OFF_FS4, 32'h0000_0002);
    `CHK(vec_addr, va(4, 1'b0))
    rdchk(vts_pkg::VTS_OFF_ISTS, 32'h0000_0016);
  endtask : t_arb

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    t_reset();
    t_bits();
    t_event();
    t_arb();
    results();
  end
endmodule : vts_top_test
